// [core/dscg_pkg.sv]
// constants, types and register map of the deep sleep clock gating block
// Operation
// - enable bit one delivers the unit clock
// - enable bit zero stops and disables unit
// - access to gated unit answers bus fault
// - all gate enables reset to zero
// - run, sleep, deep-sleep sets follow power mode
// - sleep sets used only when auto gating set
// - deep-sleep register 0x120, bits 24 and 3
// - unused gate bits reserved, read zero
package dscg_pkg;

  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam int          NUM_UNITS       = 2;

  // register byte offsets
  localparam logic [11:0] OFF_MODE_CFG    = 12'h060;
  localparam logic [11:0] OFF_RUN_GATE    = 12'h100;
  localparam logic [11:0] OFF_SLEEP_GATE  = 12'h110;
  localparam logic [11:0] OFF_DEEP_GATE   = 12'h120;
  localparam logic [11:0] OFF_IRQ_STATUS  = 12'h150;
  localparam logic [11:0] OFF_IRQ_MASK    = 12'h154;
  localparam logic [11:0] OFF_ACTIVE_GATE = 12'h158;

  // field positions
  localparam int          BIT_CAN_ZERO       = 24;
  localparam int          BIT_WATCHDOG       = 3;
  localparam int          BIT_AUTO_GATE      = 0;
  localparam int          UNIT_CAN_ZERO      = 0;
  localparam int          UNIT_WATCHDOG      = 1;
  localparam int          IRQ_FAULT_CAN_ZERO = 0;
  localparam int          IRQ_FAULT_WATCHDOG = 1;
  localparam int          IRQ_MODE_CHG    = 2;

  // writable masks and reset values
  localparam logic [31:0] GATE_MASK       = 32'h0100_0008;
  localparam logic [31:0] MODE_MASK       = 32'h0000_0001;
  localparam logic [31:0] IRQ_MASK_BITS   = 32'h0000_0007;
  localparam logic [31:0] GATE_RESET      = 32'h0000_0000;
  localparam logic [31:0] MODE_RESET      = 32'h0000_0000;
  localparam logic [31:0] IRQ_RESET       = 32'h0000_0000;

  typedef enum logic [1:0] {
    PM_RUN,
    PM_SLEEP,
    PM_DEEP
  } dscg_pmode_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dscg_bus_req_t;

endpackage : dscg_pkg

// [core/dscg_top.sv]
// clock gate enables for on-chip units, per power mode, with bus fault detection
`timescale 1ns/10ps
`default_nettype none

module dscg_clk_gate (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // enable from posedge logic
  input  wire logic en,
  // gated clock
  output wire logic gclk,
  output logic      en_lo_ff
);

  // enable moves only while clk is low, so no runt high phase reaches the unit
  always_ff @(negedge clk) begin
    if (rst) begin
      en_lo_ff <= 1'b0;
    end else begin
      en_lo_ff <= en;
    end
  end

  assign gclk = clk & en_lo_ff;

endmodule : dscg_clk_gate

module dscg_top (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // register port
  input  wire dscg_pkg::dscg_bus_req_t bus_req,
  output logic [31:0]               rdata_ff,
  // power mode from the system
  input  wire dscg_pkg::dscg_pmode_t pwr_mode,
  // unit access strobes and fault answer
  input  wire logic [1:0]           unit_acc,
  output logic                      bus_fault_ff,
  // unit clocks
  output logic [1:0]                unit_en_ff,
  output wire logic [1:0]           unit_clk,
  // interrupt
  output logic                      irq_ff
);

  logic [31:0]           run_ff;
  logic [31:0]           sleep_ff;
  logic [31:0]           deep_ff;
  logic [31:0]           mode_ff;
  logic [31:0]           irq_stat_ff;
  logic [31:0]           irq_mask_ff;
  logic [31:0]           nxt_eff;
  logic [1:0]            nxt_unit_en;
  logic [1:0]            fault_hit;
  logic [1:0]            en_lo;
  logic [31:0]           nxt_rdata;
  logic [31:0]           nxt_irq_stat;
  logic [31:0]           nxt_irq_mask;
  dscg_pkg::dscg_pmode_t mode_q_ff;
  logic                  mode_chg;
  logic                  auto_on;

  wire wr_run   = bus_req.wr && (bus_req.addr == dscg_pkg::OFF_RUN_GATE);
  wire wr_sleep = bus_req.wr && (bus_req.addr == dscg_pkg::OFF_SLEEP_GATE);
  wire wr_deep  = bus_req.wr && (bus_req.addr == dscg_pkg::OFF_DEEP_GATE);
  wire wr_mode  = bus_req.wr && (bus_req.addr == dscg_pkg::OFF_MODE_CFG);
  wire wr_stat  = bus_req.wr && (bus_req.addr == dscg_pkg::OFF_IRQ_STATUS);
  wire wr_mask  = bus_req.wr && (bus_req.addr == dscg_pkg::OFF_IRQ_MASK);

  assign auto_on = mode_ff[dscg_pkg::BIT_AUTO_GATE];

  // gate register sets; reserved bits never stored
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      run_ff   <= dscg_pkg::GATE_RESET;
      sleep_ff <= dscg_pkg::GATE_RESET;
      deep_ff  <= dscg_pkg::GATE_RESET;
    end else begin
      if (wr_run) begin
        run_ff <= bus_req.wdata & dscg_pkg::GATE_MASK;
      end
      if (wr_sleep) begin
        sleep_ff <= bus_req.wdata & dscg_pkg::GATE_MASK;
      end
      if (wr_deep) begin
        deep_ff <= bus_req.wdata & dscg_pkg::GATE_MASK;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_ff <= dscg_pkg::MODE_RESET;
    end else if (wr_mode) begin
      mode_ff <= bus_req.wdata & dscg_pkg::MODE_MASK;
    end
  end

  // set chosen by power mode, only under auto gating
  always_comb begin
    nxt_eff = run_ff;
    if (auto_on) begin
      case (pwr_mode)
        dscg_pkg::PM_SLEEP: nxt_eff = sleep_ff;
        dscg_pkg::PM_DEEP:  nxt_eff = deep_ff;
        default:            nxt_eff = run_ff;
      endcase
    end
  end

  assign nxt_unit_en = {nxt_eff[dscg_pkg::BIT_WATCHDOG], nxt_eff[dscg_pkg::BIT_CAN_ZERO]};

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      unit_en_ff <= 2'h0;
    end else begin
      unit_en_ff <= nxt_unit_en;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < dscg_pkg::NUM_UNITS; gi = gi + 1) begin : g_gate
      dscg_clk_gate u_gate (
        .clk      (ref_clk),
        .rst      (rst),
        .en       (unit_en_ff[gi]),
        .gclk     (unit_clk[gi]),
        .en_lo_ff (en_lo[gi])
      );
    end
  endgenerate

  // fault judged against the clock the unit has right now
  assign fault_hit = unit_acc & ~unit_en_ff;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bus_fault_ff <= 1'b0;
    end else begin
      bus_fault_ff <= |fault_hit;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_q_ff <= dscg_pkg::PM_RUN;
    end else begin
      mode_q_ff <= pwr_mode;
    end
  end

  assign mode_chg = (mode_q_ff != pwr_mode);

  // sticky events: a new event beats a write-one clear in the same cycle
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (wr_stat) begin
      nxt_irq_stat = irq_stat_ff & ~(bus_req.wdata & dscg_pkg::IRQ_MASK_BITS);
    end
    if (fault_hit[dscg_pkg::UNIT_CAN_ZERO]) begin
      nxt_irq_stat[dscg_pkg::IRQ_FAULT_CAN_ZERO] = 1'b1;
    end
    if (fault_hit[dscg_pkg::UNIT_WATCHDOG]) begin
      nxt_irq_stat[dscg_pkg::IRQ_FAULT_WATCHDOG] = 1'b1;
    end
    if (mode_chg) begin
      nxt_irq_stat[dscg_pkg::IRQ_MODE_CHG] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_stat_ff <= dscg_pkg::IRQ_RESET;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  // mask as it stands after this edge, so irq tracks status and mask together
  always_comb begin
    nxt_irq_mask = irq_mask_ff;
    if (wr_mask) begin
      nxt_irq_mask = bus_req.wdata & dscg_pkg::IRQ_MASK_BITS;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_mask_ff <= dscg_pkg::IRQ_RESET;
    end else begin
      irq_mask_ff <= nxt_irq_mask;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_irq_stat & nxt_irq_mask);
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (bus_req.addr)
      dscg_pkg::OFF_RUN_GATE:    nxt_rdata = run_ff;
      dscg_pkg::OFF_SLEEP_GATE:  nxt_rdata = sleep_ff;
      dscg_pkg::OFF_DEEP_GATE:   nxt_rdata = deep_ff;
      dscg_pkg::OFF_MODE_CFG:    nxt_rdata = mode_ff;
      dscg_pkg::OFF_IRQ_STATUS:  nxt_rdata = irq_stat_ff;
      dscg_pkg::OFF_IRQ_MASK:    nxt_rdata = irq_mask_ff;
      dscg_pkg::OFF_ACTIVE_GATE: nxt_rdata = {30'h0, unit_en_ff};
      default:                   nxt_rdata = 32'h0000_0000;
    endcase
  end

  // data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (bus_req.rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= 32'h0000_0000;
    end
  end

  // checks
  gate_on_a : assert property (@(posedge ref_clk) disable iff (rst)
    nxt_unit_en[dscg_pkg::UNIT_CAN_ZERO] |=>
      unit_en_ff[dscg_pkg::UNIT_CAN_ZERO] && en_lo[dscg_pkg::UNIT_CAN_ZERO])
    else $error("enabled unit did not get its clock");

  wdog_on_a : assert property (@(posedge ref_clk) disable iff (rst)
    nxt_unit_en[dscg_pkg::UNIT_WATCHDOG] |=>
      unit_en_ff[dscg_pkg::UNIT_WATCHDOG] && en_lo[dscg_pkg::UNIT_WATCHDOG])
    else $error("enabled watchdog did not get its clock");

  // the low-phase copy must fall as well, or the unit keeps ticking
  gate_off_a : assert property (@(posedge ref_clk) disable iff (rst)
    !nxt_unit_en[dscg_pkg::UNIT_WATCHDOG] |=>
      !unit_en_ff[dscg_pkg::UNIT_WATCHDOG] && !en_lo[dscg_pkg::UNIT_WATCHDOG])
    else $error("disabled unit still clocked");

  can_off_a : assert property (@(posedge ref_clk) disable iff (rst)
    !nxt_unit_en[dscg_pkg::UNIT_CAN_ZERO] |=>
      !unit_en_ff[dscg_pkg::UNIT_CAN_ZERO] && !en_lo[dscg_pkg::UNIT_CAN_ZERO])
    else $error("disabled can unit still clocked");

  fault_answer_a : assert property (@(posedge ref_clk) disable iff (rst)
    (unit_acc != 2'h0) |=> (bus_fault_ff == |$past(unit_acc & ~unit_en_ff)))
    else $error("bus fault does not match gate state");

  fault_none_a : assert property (@(posedge ref_clk) disable iff (rst)
    ((unit_acc & ~unit_en_ff) == 2'h0) |=> !bus_fault_ff)
    else $error("bus fault raised for a clocked unit");

  // set must win over a clear written in the same cycle
  can_sticky_a : assert property (@(posedge ref_clk) disable iff (rst)
    unit_acc[dscg_pkg::UNIT_CAN_ZERO] && !unit_en_ff[dscg_pkg::UNIT_CAN_ZERO] |=>
      irq_stat_ff[dscg_pkg::IRQ_FAULT_CAN_ZERO])
    else $error("can fault lost from status");

  wdog_sticky_a : assert property (@(posedge ref_clk) disable iff (rst)
    unit_acc[dscg_pkg::UNIT_WATCHDOG] && !unit_en_ff[dscg_pkg::UNIT_WATCHDOG] |=>
      irq_stat_ff[dscg_pkg::IRQ_FAULT_WATCHDOG])
    else $error("watchdog fault lost from status");

  reset_zero_a : assert property (@(posedge ref_clk)
    rst |=> (run_ff == 32'h0000_0000) && (sleep_ff == 32'h0000_0000) &&
      (deep_ff == 32'h0000_0000) && (unit_en_ff == 2'h0))
    else $error("gate enables not zero after reset");

  deep_select_a : assert property (@(posedge ref_clk) disable iff (rst)
    auto_on && (pwr_mode == dscg_pkg::PM_DEEP) |=>
      unit_en_ff == {$past(deep_ff[dscg_pkg::BIT_WATCHDOG]),
                     $past(deep_ff[dscg_pkg::BIT_CAN_ZERO])})
    else $error("deep-sleep set not applied");

  sleep_select_a : assert property (@(posedge ref_clk) disable iff (rst)
    auto_on && (pwr_mode == dscg_pkg::PM_SLEEP) |=>
      unit_en_ff == {$past(sleep_ff[dscg_pkg::BIT_WATCHDOG]),
                     $past(sleep_ff[dscg_pkg::BIT_CAN_ZERO])})
    else $error("sleep set not applied");

  run_kept_a : assert property (@(posedge ref_clk) disable iff (rst)
    !auto_on |=>
      unit_en_ff == {$past(run_ff[dscg_pkg::BIT_WATCHDOG]),
                     $past(run_ff[dscg_pkg::BIT_CAN_ZERO])})
    else $error("sleep set used without auto gating");

  // the bus master leaves one idle cycle between a write and the next read
  deep_read_a : assert property (@(posedge ref_clk) disable iff (rst)
    wr_deep ##1 !wr_deep ##1 (bus_req.rd && (bus_req.addr == dscg_pkg::OFF_DEEP_GATE)) |=>
      rdata_ff == ($past(bus_req.wdata, 3) & dscg_pkg::GATE_MASK))
    else $error("deep-sleep register readback wrong");

  reserved_zero_a : assert property (@(posedge ref_clk) disable iff (rst)
    ((run_ff | sleep_ff | deep_ff) & ~dscg_pkg::GATE_MASK) == 32'h0000_0000)
    else $error("reserved gate bit stored");

  gate_follow_a : assert property (@(posedge ref_clk) disable iff (rst)
    $past(!rst) |-> en_lo == unit_en_ff)
    else $error("gate enable moved outside low phase");

  irq_level_a : assert property (@(posedge ref_clk) disable iff (rst)
    irq_ff == ((irq_stat_ff & irq_mask_ff) != 32'h0000_0000))
    else $error("interrupt does not follow unmasked status");

  stat_clear_a : assert property (@(posedge ref_clk) disable iff (rst)
    wr_stat && bus_req.wdata[dscg_pkg::IRQ_MODE_CHG] && !mode_chg |=>
      !irq_stat_ff[dscg_pkg::IRQ_MODE_CHG])
    else $error("status bit not cleared by write one");

  mode_event_a : assert property (@(posedge ref_clk) disable iff (rst)
    mode_chg |=> irq_stat_ff[dscg_pkg::IRQ_MODE_CHG])
    else $error("power mode change not recorded");

  active_read_a : assert property (@(posedge ref_clk) disable iff (rst)
    bus_req.rd && (bus_req.addr == dscg_pkg::OFF_ACTIVE_GATE) |=>
      rdata_ff == {30'h0, $past(unit_en_ff)})
    else $error("active enables read back wrong");

  rdata_idle_a : assert property (@(posedge ref_clk) disable iff (rst)
    !bus_req.rd |=> rdata_ff == 32'h0000_0000)
    else $error("read data outside its cycle");

  deep_entry_c : cover property (@(posedge ref_clk) disable iff (rst)
    auto_on && mode_q_ff == dscg_pkg::PM_RUN && pwr_mode == dscg_pkg::PM_DEEP);

  sleep_entry_c : cover property (@(posedge ref_clk) disable iff (rst)
    auto_on && pwr_mode == dscg_pkg::PM_SLEEP && unit_en_ff != 2'h0);

  fault_seen_c : cover property (@(posedge ref_clk) disable iff (rst) bus_fault_ff);

  unit_on_c : cover property (@(posedge ref_clk) disable iff (rst)
    $rose(unit_en_ff[dscg_pkg::UNIT_CAN_ZERO]));

  irq_raise_c : cover property (@(posedge ref_clk) disable iff (rst) $rose(irq_ff));

endmodule : dscg_top

`default_nettype wire

// [tb/dscg_unit_model.sv]
// behavioural model of the units fed by the gated clocks
`timescale 1ns/10ps
`default_nettype none

module dscg_unit_model (
  // gated unit clocks
  input  wire logic [1:0]  unit_clk,
  // pulses seen per unit and pulses cut short
  output logic [1:0][15:0] pulse_cnt,
  output logic [15:0]      short_cnt
);
  realtime rise_t [2];

  initial begin
    pulse_cnt = '0;
    short_cnt = 16'h0000;
  end

  for (genvar i = 0; i < 2; i++) begin : g_unit
    always @(posedge unit_clk[i]) begin
      pulse_cnt[i] <= pulse_cnt[i] + 16'h0001;
      rise_t[i] = $realtime;
    end
    // a full pulse is half of the 100 ns period
    always @(negedge unit_clk[i]) begin
      if ($realtime - rise_t[i] < 50.0) short_cnt <= short_cnt + 16'h0001;
    end
  end
endmodule : dscg_unit_model

`default_nettype wire

// [tb/deep_sleep_clock_gating_test.sv]
// self-checking bench of the deep sleep clock gating block
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end

module deep_sleep_clock_gating_test;
  typedef struct packed {
    logic                  auto_sel;
    dscg_pkg::dscg_pmode_t mode;
    logic [31:0]           run;
    logic [31:0]           slp;
    logic [31:0]           deep;
    logic [1:0]            en;
  } dscg_row_t;

  logic                    ref_clk  = 1'b0;
  logic                    rst      = 1'b1;
  dscg_pkg::dscg_bus_req_t bus_req  = '0;
  dscg_pkg::dscg_pmode_t   pwr_mode = dscg_pkg::PM_RUN;
  logic [1:0]              unit_acc = 2'h0;
  logic [31:0]             rdata_ff;
  logic                    bus_fault_ff;
  logic [1:0]              unit_en_ff;
  wire logic [1:0]         unit_clk;
  logic                    irq_ff;
  logic [1:0][15:0]        pulse_cnt;
  logic [1:0][15:0]        cnt_snap;
  logic [15:0]             short_cnt;
  logic [31:0]             rd_val;
  int                      err_total = 0;
  int                      checks    = 0;
  int                      cyc       = 0;
  dscg_row_t               rows [6];
  logic [11:0]             gate_offs [4];

  dscg_top i_dscg_top (
    .ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .rdata_ff(rdata_ff),
    .pwr_mode(pwr_mode), .unit_acc(unit_acc), .bus_fault_ff(bus_fault_ff),
    .unit_en_ff(unit_en_ff), .unit_clk(unit_clk), .irq_ff(irq_ff)
  );

  dscg_unit_model i_dscg_unit_model (
    .unit_clk(unit_clk), .pulse_cnt(pulse_cnt), .short_cnt(short_cnt)
  );

  always #50 ref_clk = ~ref_clk;

  // whole run needs well under 1000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      test_done();
    end
  end

  task automatic test_done();
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  task automatic ticks(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : ticks

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    @(negedge ref_clk);
    d = rdata_ff;
  endtask : rd

  initial begin
    rows[0] = '{1'b0, dscg_pkg::PM_RUN,   32'h0100_0008, 32'h0, 32'h0, 2'h3};
    rows[1] = '{1'b0, dscg_pkg::PM_DEEP,  32'h0100_0000, 32'h0, 32'h8, 2'h1};
    rows[2] = '{1'b1, dscg_pkg::PM_DEEP,  32'h0100_0000, 32'h0, 32'h8, 2'h2};
    rows[3] = '{1'b1, dscg_pkg::PM_SLEEP, 32'h0, 32'h0100_0000, 32'h8, 2'h1};
    rows[4] = '{1'b1, dscg_pkg::PM_RUN,   32'h8, 32'h0100_0000, 32'h0, 2'h2};
    rows[5] = '{1'b0, dscg_pkg::PM_SLEEP, 32'h0, 32'h0100_0008, 32'h0, 2'h0};
    gate_offs = '{dscg_pkg::OFF_MODE_CFG, dscg_pkg::OFF_RUN_GATE,
                  dscg_pkg::OFF_SLEEP_GATE, dscg_pkg::OFF_DEEP_GATE};
    ticks(6);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(dscg_pkg::OFF_MODE_CFG, {31'h0, rows[i].auto_sel});
      wr(dscg_pkg::OFF_RUN_GATE, rows[i].run);
      wr(dscg_pkg::OFF_SLEEP_GATE, rows[i].slp);
      wr(dscg_pkg::OFF_DEEP_GATE, rows[i].deep);
      pwr_mode <= rows[i].mode;
      ticks(3);
      @(negedge ref_clk);
      `CHK(unit_en_ff, rows[i].en)
      cnt_snap = pulse_cnt;
      ticks(8);
      @(negedge ref_clk);
      `CHK(pulse_cnt[0] - cnt_snap[0], rows[i].en[0] ? 16'h8 : 16'h0)
      `CHK(pulse_cnt[1] - cnt_snap[1], rows[i].en[1] ? 16'h8 : 16'h0)
      rd(dscg_pkg::OFF_ACTIVE_GATE, rd_val);
      `CHK(rd_val, {30'h0, rows[i].en})
    end
    // reserved bits of the deep set, then an unmapped word
    wr(dscg_pkg::OFF_DEEP_GATE, 32'hffff_ffff);
    rd(dscg_pkg::OFF_DEEP_GATE, rd_val);
    `CHK(rd_val, 32'h0100_0008)
    rd(12'h124, rd_val);
    `CHK(rd_val, 32'h0000_0000)
    // both units gated now; only the can fault is let through to irq
    wr(dscg_pkg::OFF_IRQ_STATUS, 32'h0000_0007);
    wr(dscg_pkg::OFF_IRQ_MASK, 32'h0000_0001);
    @(posedge ref_clk);
    unit_acc <= 2'h2;
    @(posedge ref_clk);
    unit_acc <= 2'h1;
    @(negedge ref_clk);
    `CHK({bus_fault_ff, irq_ff}, 2'b10)
    @(posedge ref_clk);
    unit_acc <= 2'h0;
    @(negedge ref_clk);
    `CHK({bus_fault_ff, irq_ff}, 2'b11)
    rd(dscg_pkg::OFF_IRQ_STATUS, rd_val);
    `CHK(rd_val, 32'h0000_0003)
    wr(dscg_pkg::OFF_IRQ_STATUS, 32'h0000_0003);
    ticks(2);
    @(negedge ref_clk);
    `CHK(irq_ff, 1'b0)
    // clocked unit answers without a fault
    wr(dscg_pkg::OFF_RUN_GATE, 32'h0100_0000);
    ticks(3);
    unit_acc <= 2'h1;
    ticks(1);
    unit_acc <= 2'h0;
    @(negedge ref_clk);
    `CHK(bus_fault_ff, 1'b0)
    `CHK(short_cnt, 16'h0000)
    // second reset in mid-run with a unit clocked
    @(posedge ref_clk);
    pwr_mode <= dscg_pkg::PM_RUN;
    rst <= 1'b1;
    ticks(6);
    rst <= 1'b0;
    @(negedge ref_clk);
    `CHK({unit_en_ff, irq_ff}, 3'b000)
    foreach (gate_offs[i]) begin
      rd(gate_offs[i], rd_val);
      `CHK(rd_val, 32'h0000_0000)
    end
    test_done();
  end
endmodule : deep_sleep_clock_gating_test

`default_nettype wire
